/* iocs_cell.sv */
// Storage and control logic of one configurable I/O cell
`default_nettype none

module iocs_cell (
    input  wire logic       mclk,              // System clock, 100 MHz
    input  wire logic       rst,               // Synchronous reset, active high
    input  wire logic       global_init_pulse, // Global set/reset, active high
    input  wire logic       init_value_in,     // Input element init: 1 set, 0 clear
    input  wire logic       init_value_out,    // Output element init: 1 set, 0 clear
    input  wire logic       pad_i,             // Level seen at the pad
    input  wire logic       in_clk_pin,        // Input element clock
    input  wire logic       out_clk_pin,       // Output flop and early latch clock
    input  wire logic       in_clk_invert,     // Invert input clock in cell
    input  wire logic       out_clk_invert,    // Invert output clock in cell
    input  wire logic       in_as_latch,       // Input element is a latch
    input  wire logic       early_capture_latch,      // Early latch in path
    input  wire logic       capture_latch_then_latch, // Second stage is latch
    input  wire logic       two_tap,           // Two-tap delay variant
    input  wire logic       delay_explicit,    // Delay chosen explicitly
    input  wire logic [1:0] delay_req,         // Requested delay code
    input  wire logic       ce,                // Shared clock enable
    input  wire logic       ce_connected,      // Enable input is wired
    input  wire logic       ce_apply_in,       // Enable gates input element
    input  wire logic       ce_apply_out,      // Enable gates output flop
    input  wire logic       out_data,          // Output value from array
    input  wire logic       out_invert,        // Invert output value
    input  wire logic       out_registered,    // Output through flop
    input  wire logic       tri_ctl,           // Three-state control
    input  wire logic       tri_connected,     // Three-state input is wired
    input  wire logic       tri_invert,        // Invert three-state control
    output logic            pad_o,             // Value driven to pad
    output logic            pad_oe,            // Pad driver enable, high drives
    output logic            in_direct,         // Direct input to array
    output logic            in_registered,     // Stored input to array
    output logic      [1:0] delay_setting      // Effective delay code
);

    typedef struct packed {
        logic       ick_prev;
        logic       ock_prev;
        logic       early_lat;
        logic       in_reg;
        logic       out_reg;
        logic       pad_o;
        logic       pad_oe;
        logic       in_direct;
        logic [1:0] delay;
    } iocs_state_t;

    iocs_state_t st_q;
    iocs_state_t st_d;

    logic [2:0] sync_q;
    logic       pad_s;
    logic       ick;
    logic       ock;
    logic       ick_rise;
    logic       ock_rise;
    logic       init;
    logic       ce_eff;
    logic       ce_in;
    logic       ce_out;
    logic       out_val;
    logic       tri_active;
    logic       stage2_src;

    // ==========================================================
    // Pin synchronisers for pad and both cell clocks
    iocs_sync #(
        .W (3)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({out_clk_pin, in_clk_pin, pad_i}),
        .q    (sync_q)
    );

    // ==========================================================
    // Clock polarity, edges and control defaults
    always_comb begin
        pad_s      = sync_q[0];
        ick        = sync_q[1] ^ in_clk_invert;
        ock        = sync_q[2] ^ out_clk_invert;
        ick_rise   = ick & ~st_q.ick_prev;
        ock_rise   = ock & ~st_q.ock_prev;
        init       = global_init_pulse;
        ce_eff     = ce_connected ? ce : iocs_pkg::CE_OPEN_LVL;
        ce_in      = ce_apply_in ? ce_eff : 1'h1;
        ce_out     = ce_apply_out ? ce_eff : 1'h1;
        out_val    = out_data ^ out_invert;
        tri_active = (tri_connected ? tri_ctl : iocs_pkg::T_OPEN_LVL) ^ tri_invert;
        stage2_src = early_capture_latch ? st_q.early_lat : pad_s;
    end

    // ==========================================================
    // Next state of the whole cell
    always_comb begin
        st_d           = st_q;
        st_d.ick_prev  = ick;
        st_d.ock_prev  = ock;
        st_d.in_direct = pad_s;
        // Delay code only; sampled data path is unchanged
        if (!two_tap) begin
            st_d.delay = (delay_explicit && delay_req == iocs_pkg::DLY_BYPASS) ?
                         iocs_pkg::DLY_BYPASS : iocs_pkg::DLY_FULL;
        end else if (delay_explicit) begin
            st_d.delay = (delay_req == iocs_pkg::DLY_PARTIAL || delay_req == iocs_pkg::DLY_BYPASS) ?
                         delay_req : iocs_pkg::DLY_FULL;
        end else begin
            st_d.delay = early_capture_latch ? iocs_pkg::DLY_PARTIAL : iocs_pkg::DLY_FULL;
        end
        // Early latch on output clock, transparent Low
        if (!ock) begin
            st_d.early_lat = pad_s;
        end
        // Input element: second stage picks flop or High latch, plain one flop or Low latch
        if (ce_in) begin
            if (early_capture_latch) begin
                if (capture_latch_then_latch ? ick : ick_rise) begin
                    st_d.in_reg = stage2_src;
                end
            end else if (in_as_latch ? !ick : ick_rise) begin
                st_d.in_reg = stage2_src;
            end
        end
        // Output flop: rising edge with enable High
        if (ock_rise && ce_out) begin
            st_d.out_reg = out_val;
        end
        // Pad drive; open drain is data Low with signal on three-state
        st_d.pad_o  = out_registered ? st_d.out_reg : out_val;
        st_d.pad_oe = ~tri_active;
        // Global init overrides storage with configured values
        if (init) begin
            st_d.early_lat = init_value_in;
            st_d.in_reg  = init_value_in;
            st_d.out_reg = init_value_out;
            st_d.pad_o   = out_registered ? init_value_out : out_val;
        end
    end

    // ==========================================================
    // State register with power-up load
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q           <= '0;
            st_q.early_lat <= init_value_in;
            st_q.in_reg    <= init_value_in;
            st_q.out_reg   <= init_value_out;
            st_q.pad_o     <= iocs_pkg::RST_BIT;
            st_q.pad_oe   <= iocs_pkg::RST_OE;
            st_q.delay    <= iocs_pkg::RST_DELAY;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign pad_o         = st_q.pad_o;
    assign pad_oe        = st_q.pad_oe;
    assign in_direct     = st_q.in_direct;
    assign in_registered = st_q.in_reg;
    assign delay_setting = st_q.delay;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_ce_open;
        (!ce_connected && ock_rise && !init) |=> st_q.out_reg == $past(out_val);
    endproperty
    a_ce_open: assert property (p_ce_open) else $error("open enable did not capture");

    property p_tri_open;
        (!tri_connected && !tri_invert) |=> pad_oe;
    endproperty
    a_tri_open: assert property (p_tri_open) else $error("open three-state not driving");

    property p_init_load;
        init |=> (in_registered == $past(init_value_in)) && (st_q.out_reg == $past(init_value_out));
    endproperty
    a_init_load: assert property (p_init_load) else $error("init value not loaded");

    property p_one_tap;
        (!two_tap && !delay_explicit) |=> delay_setting == iocs_pkg::DLY_FULL;
    endproperty
    a_one_tap: assert property (p_one_tap) else $error("single tap default wrong");

    property p_two_tap_sel;
        (two_tap && delay_explicit && delay_req == iocs_pkg::DLY_PARTIAL) |=> delay_setting == iocs_pkg::DLY_PARTIAL;
    endproperty
    a_two_tap_sel: assert property (p_two_tap_sel) else $error("partial delay not selected");

    property p_early_delay;
        (two_tap && !delay_explicit && early_capture_latch) |=> delay_setting == iocs_pkg::DLY_PARTIAL;
    endproperty
    a_early_delay: assert property (p_early_delay) else $error("early capture default wrong");

    property p_early_latch;
        (!ock && !init) |=> st_q.early_lat == $past(pad_s);
    endproperty
    a_early_latch: assert property (p_early_latch) else $error("early latch not transparent");

    property p_tri_off;
        tri_active |=> !pad_oe ##1 (pad_oe == !$past(tri_active));
    endproperty
    a_tri_off: assert property (p_tri_off) else $error("pad driven while three-stated");

    property p_out_hold;
        (!(ock_rise && ce_out) && !init) |=> $stable(st_q.out_reg);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output flop changed without edge");

    property p_direct_out;
        (!out_registered && !init) |=> pad_o == $past(out_val);
    endproperty
    a_direct_out: assert property (p_direct_out) else $error("direct output mismatch");

    property p_in_hold;
        (!ce_in && !init) |=> $stable(in_registered);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input element changed while disabled");

endmodule

`default_nettype wire

/* iocs_cell_bench.sv */
// Self-checking bench for the I/O cell storage logic
`default_nettype none

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module iocs_cell_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic       mclk, rst, global_init_pulse, init_value_in, init_value_out, pad_i;
    logic       in_clk_pin, out_clk_pin, in_clk_invert, out_clk_invert, in_as_latch;
    logic       early_capture_latch, capture_latch_then_latch, two_tap, delay_explicit;
    logic [1:0] delay_req, delay_setting;
    logic       ce, ce_connected, ce_apply_in, ce_apply_out, out_data, out_invert;
    logic       out_registered, tri_ctl, tri_connected, tri_invert, ext_drive, ext_level;
    logic       pad_o, pad_oe, in_direct, in_registered;
    int         miscompares, check_count, cycles;

    iocs_cell iocs_cell_inst (.mclk, .rst, .global_init_pulse, .init_value_in, .init_value_out,
        .pad_i, .in_clk_pin, .out_clk_pin, .in_clk_invert, .out_clk_invert, .in_as_latch,
        .early_capture_latch, .capture_latch_then_latch, .two_tap, .delay_explicit, .delay_req,
        .ce, .ce_connected, .ce_apply_in, .ce_apply_out, .out_data, .out_invert, .out_registered,
        .tri_ctl, .tri_connected, .tri_invert, .pad_o, .pad_oe, .in_direct, .in_registered,
        .delay_setting);
    iocs_pad_model iocs_pad_model_inst (.pad_o, .pad_oe, .ext_drive, .ext_level, .pad_i);

    // ==========================================================
    // Clock, watchdog and closing report
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end

    // ==========================================================
    // Pin access tasks, all changes on the falling edge
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse_out;
        out_clk_pin = 1'h1;
        step(6);
        out_clk_pin = 1'h0;
        step(6);
    endtask
    task automatic pulse_in;
        in_clk_pin = 1'h1;
        step(6);
        in_clk_pin = 1'h0;
        step(6);
    endtask
    // Effective delay code expected from the variant and selection
    function automatic logic [1:0] exp_dly(logic tt, logic ex, logic ecl, logic [1:0] rq);
        if (!tt) return (ex && rq == iocs_pkg::DLY_BYPASS) ? iocs_pkg::DLY_BYPASS : iocs_pkg::DLY_FULL;
        if (ex) return (rq == 2'h3) ? iocs_pkg::DLY_FULL : rq;
        return ecl ? iocs_pkg::DLY_PARTIAL : iocs_pkg::DLY_FULL;
    endfunction

    // ==========================================================
    // Test sequence
    initial begin
        {global_init_pulse, init_value_in, init_value_out, in_clk_pin, out_clk_pin} = '0;
        {in_clk_invert, out_clk_invert, in_as_latch, early_capture_latch} = '0;
        {capture_latch_then_latch, two_tap, delay_explicit, delay_req, ce_apply_in} = '0;
        {ce_apply_out, out_data, out_invert, out_registered, tri_ctl, tri_invert} = '0;
        {ext_drive, ext_level, miscompares, check_count, cycles} = '0;
        {rst, ce, ce_connected, tri_connected} = 4'hf;
        step(6);
        `CHK("pad_oe rst", 1'h0, pad_oe)
        `CHK("in_registered rst", 1'h0, in_registered)
        rst = 1'h0;
        // Delay selection across variants
        for (int i = 0; i < 32; i++) begin
            {two_tap, delay_explicit, early_capture_latch, delay_req} = i[4:0];
            step(2);
            `CHK("delay_setting", exp_dly(i[4], i[3], i[2], i[1:0]), delay_setting)
        end
        early_capture_latch = 1'h0;
        // Direct output path and three-state polarity
        for (int i = 0; i < 8; i++) begin
            {out_data, out_invert} = i[1:0];
            {tri_connected, tri_ctl, tri_invert} = {i[2], i[1], i[2] & i[0]};
            step(2);
            `CHK("pad_o direct", i[0] ^ i[1], pad_o)
            `CHK("pad_oe", ~((tri_connected ? tri_ctl : iocs_pkg::T_OPEN_LVL) ^ tri_invert), pad_oe)
        end
        // Open drain: data Low, signal on three-state
        {out_data, out_invert, tri_invert, tri_connected} = 4'h1;
        for (int s = 0; s < 2; s++) begin
            tri_ctl = s[0];
            step(10);
            `CHK("pad_oe od", ~s[0], pad_oe)
            `CHK("in_direct od", s[0], in_direct)
        end
        // Output flop: enable, unconnected enable, apply select, clock invert
        {tri_ctl, out_registered, ce_apply_out, ce, out_data} = 5'h0d;
        pulse_out();
        `CHK("pad_o hold", 1'h0, pad_o)
        ce = 1'h1;
        pulse_out();
        `CHK("pad_o capture", 1'h1, pad_o)
        {out_data, ce_connected, ce} = 3'h0;
        pulse_out();
        `CHK("pad_o open ce", 1'h0, pad_o)
        {ce_apply_out, ce_connected, out_data, out_invert} = 4'h5;
        pulse_out();
        `CHK("pad_o inv reg", 1'h1, pad_o)
        {out_invert, out_data, out_clk_invert} = 3'h1;
        step(8);
        out_data = 1'h1;
        out_clk_pin = 1'h1;
        step(8);
        `CHK("pad_o inv clk rise", 1'h0, pad_o)
        out_clk_pin = 1'h0;
        step(8);
        `CHK("pad_o inv clk fall", 1'h1, pad_o)
        out_clk_invert = 1'h0;
        step(4);
        // Global init loads set then clear values
        for (int v = 1; v >= 0; v--) begin
            {global_init_pulse, init_value_in, init_value_out} = {1'h1, v[0], v[0]};
            step(2);
            global_init_pulse = 1'h0;
            step(1);
            `CHK("pad_o init", v[0], pad_o)
            `CHK("in_registered init", v[0], in_registered)
        end
        // Input flop with enable, pad driven from outside
        {tri_ctl, ext_drive, ext_level} = 3'h7;
        step(10);
        `CHK("in_direct", 1'h1, in_direct)
        pulse_in();
        `CHK("in flop", 1'h1, in_registered)
        {ce_apply_in, ce, ext_level} = 3'h4;
        step(10);
        pulse_in();
        `CHK("in flop hold", 1'h1, in_registered)
        ce = 1'h1;
        pulse_in();
        `CHK("in flop ce", 1'h0, in_registered)
        // Early latch on output clock ahead of input flop, then latch pair
        {early_capture_latch, ext_level} = 2'h3;
        step(10);
        out_clk_pin = 1'h1;
        step(8);
        ext_level = 1'h0;
        step(10);
        pulse_in();
        `CHK("early latch held", 1'h1, in_registered)
        {capture_latch_then_latch, out_clk_pin, in_clk_pin, ext_level} = 4'ha;
        step(14);
        `CHK("latch pair open", 1'h0, in_registered)
        in_clk_pin = 1'h0;
        step(8);
        ext_level = 1'h1;
        step(14);
        `CHK("latch pair hold", 1'h0, in_registered)
        // Plain input latch, transparent while its clock is Low
        {early_capture_latch, capture_latch_then_latch, in_as_latch} = 3'h1;
        step(4);
        `CHK("in latch open", 1'h1, in_registered)
        in_clk_pin = 1'h1;
        step(8);
        ext_level = 1'h0;
        step(10);
        `CHK("in latch hold", 1'h1, in_registered)
        // Mid-run reset loads the configured set value
        {rst, init_value_in, init_value_out, in_clk_pin} = 4'he;
        step(2);
        `CHK("in_registered rst set", 1'h1, in_registered)
        rst = 1'h0;
        conclude();
    end
endmodule

`default_nettype wire

/* iocs_pad_model.sv */
// Pad model resolving cell driver, outside driver and pull-up into one level
`default_nettype none

module iocs_pad_model (
    input  wire logic pad_o,     // Value from the cell
    input  wire logic pad_oe,    // Cell drives pad when high
    input  wire logic ext_drive, // Outside party drives pad
    input  wire logic ext_level, // Outside party's level
    output logic      pad_i      // Resolved pad level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Cell driver wins, then outside driver, else pull-up holds High
    assign pad_i = pad_oe ? pad_o : (ext_drive ? ext_level : 1'h1);
endmodule

`default_nettype wire

/* iocs_pkg.sv */
// Shared constants for the configurable I/O cell storage logic
`default_nettype none

package iocs_pkg;

    // ==========================================================
    // Synchroniser depth for pad and clock pins
    localparam int unsigned SYNC_STAGES = 3;

    // ==========================================================
    // Input delay setting codes
    localparam logic [1:0] DLY_FULL    = 2'h0;  // Full delay, default
    localparam logic [1:0] DLY_PARTIAL = 2'h1;  // Partial_input_delay
    localparam logic [1:0] DLY_BYPASS  = 2'h2;  // Bypass_input_delay

    // ==========================================================
    // Values after reset
    localparam logic       RST_BIT     = 1'h0;  // Pad output bit
    localparam logic [1:0] RST_DELAY   = DLY_FULL;
    localparam logic       RST_OE      = 1'h0;  // Pad released during reset

    // ==========================================================
    // Level assumed for an unconnected control input
    localparam logic       CE_OPEN_LVL = 1'h1;  // Enable floats High
    localparam logic       T_OPEN_LVL  = 1'h0;  // Three-state floats Low

endpackage

`default_nettype wire

/* iocs_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`default_nettype none

module iocs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,   // System clock
    input  wire logic         rst,    // Synchronous reset, active high
    input  wire logic [W-1:0] d,      // Asynchronous pin levels
    output logic      [W-1:0] q       // Filtered, synchronised levels
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } iocs_sync_t;

    iocs_sync_t st_q;
    iocs_sync_t st_d;

    // ==========================================================
    // Next state: shift, accept a bit once stages two and three agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < int'(W); i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.q;

endmodule

`default_nettype wire
